// *** src/event_time_tagger_core.sv ***
// Event time-tagging core: edge selection, gating, dead time, tag queue, time scale and aux pulses.
// Assumes all pins synchronous to CLK, an external PLL that reports lock, and a Wishbone master.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Each event input registers rising, falling or both edges, chosen by software.
// - Second input is accepted only while the gate input is low.
// - A rising edge on the trigger input starts the measurement once software has armed it.
// - Rising edge of the second marker aligns the time scale to external seconds.
// - Aux output pulses periodically; period 40 ns to 1 ms in 10 ns steps.
// - Each aux pulse lasts one 100 ns clock cycle, so periods up to 100 ns hold the output high.
// - After an accepted event both inputs are ignored for the dead time.
// - Timing comes from an internal clock locked to the reference input.
// - Reference of 5 or 10 MHz is accepted; lock follows the present one.
// - Measurement is continuous; accepted events are tagged and queued, and those finding the queue full are counted as drops.
// - Both event inputs merge into one channel through a logical OR.
// - Tags hold a 10 ns coarse count plus an interpolator phase code.
module event_time_tagger_core
(
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Wishbone slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// Event inputs with interpolator phase codes
	input wire logic EVENT_A,
	input wire logic EVENT_B,
	input wire logic [7:0] PHASE_A,
	input wire logic [7:0] PHASE_B,
	input wire logic GATE_B_IN,
	// Trigger and second marker
	input wire logic MEASURE_TRIGGER_IN,
	input wire logic SECOND_MARK_IN,
	// Reference lock
	input wire logic REF_IS_10M,
	input wire logic PLL_LOCKED,
	output logic REF_SEL_10M,
	// Auxiliary pulse output
	output logic AUX_OUT
);

	function automatic logic edge_hit(input logic cur, input logic prev, input logic [1:0] mode);
		edge_hit = ((mode & tagger_pkg::EDGE_RISE) != 2'h0 && cur && !prev)
			|| ((mode & tagger_pkg::EDGE_FALL) != 2'h0 && !cur && prev);
	endfunction : edge_hit

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		merge_bytes = res;
	endfunction : merge_bytes

	// Registers
	logic [5:0] ctrl;
	logic [16:0] aux_period;
	logic [31:0] drops;
	tagger_pkg::measure_state_type state;
	logic prev_a;
	logic prev_b;
	logic prev_trig;
	logic prev_pps;
	logic [3:0] dead;
	logic [26:0] coarse;
	logic [15:0] seconds;
	logic [17:0] aux_acc;
	logic [3:0] aux_len;
	logic locked;
	logic [tagger_pkg::FIFO_AW:0] wr_ptr;
	logic [tagger_pkg::FIFO_AW:0] rd_ptr;
	tagger_pkg::tag_type head;
	logic head_ok;
	logic read_valid;

	// Bus decode
	wire logic bus_req = CYC_I && STB_I;
	wire logic bus_done = bus_req && ACK_O;
	wire logic bus_wr = bus_done && WE_I;
	wire logic wr_ctrl = bus_wr && ADR_I == tagger_pkg::ADDR_CTRL;
	wire logic wr_period = bus_wr && ADR_I == tagger_pkg::ADDR_AUX_PERIOD;
	wire logic wr_drops = bus_wr && ADR_I == tagger_pkg::ADDR_DROPS;
	wire logic rd_pop = bus_done && !WE_I && ADR_I == tagger_pkg::ADDR_TAG_LO;

	// Queue state
	wire logic [tagger_pkg::FIFO_AW:0] fill = wr_ptr - rd_ptr;
	wire logic fifo_empty = fill == '0;
	wire logic fifo_full = fill == tagger_pkg::FIFO_DEPTH;
	// The head register lags a push into an empty queue by one cycle; until then it reads as empty
	wire logic head_ready = !fifo_empty && head_ok;
	wire logic pop = rd_pop && read_valid;

	// Event path
	wire logic [1:0] edge_a = ctrl[tagger_pkg::CTRL_EDGE_A_LSB +: 2];
	wire logic [1:0] edge_b = ctrl[tagger_pkg::CTRL_EDGE_B_LSB +: 2];
	wire logic hit_a = edge_hit(EVENT_A, prev_a, edge_a);
	wire logic hit_b = edge_hit(EVENT_B, prev_b, edge_b) && !GATE_B_IN;
	wire logic running = state == tagger_pkg::ST_RUNNING;
	wire logic accept = running && dead == 4'h0 && (hit_a || hit_b);
	wire logic push = accept && !fifo_full;
	wire logic [1:0] marker = (hit_a ? tagger_pkg::MARK_A : 2'h0)
		| (hit_b ? tagger_pkg::MARK_B : 2'h0);
	wire logic [7:0] phase = hit_a ? PHASE_A : PHASE_B;
	wire tagger_pkg::tag_type new_tag = '{marker, seconds, coarse, phase};

	// Time scale
	wire logic pps_rise = SECOND_MARK_IN && !prev_pps;
	wire logic trig_rise = MEASURE_TRIGGER_IN && !prev_trig;
	wire logic [27:0] coarse_sum = {1'b0, coarse} + 28'(tagger_pkg::QUANTA_PER_CLK);
	wire logic coarse_wrap = coarse_sum >= {1'b0, tagger_pkg::QUANTA_PER_SECOND};

	// Aux accumulator, in quanta
	wire logic [17:0] aux_sum = aux_acc + 18'(tagger_pkg::QUANTA_PER_CLK);
	wire logic aux_fire = aux_sum >= {1'b0, aux_period};
	wire logic [31:0] period_word = merge_bytes({15'h0, aux_period}, DAT_I, SEL_I);
	wire logic [16:0] period_clamped = (period_word < 32'(tagger_pkg::AUX_PERIOD_MIN))
		? tagger_pkg::AUX_PERIOD_MIN
		: (period_word > 32'(tagger_pkg::AUX_PERIOD_MAX))
		? tagger_pkg::AUX_PERIOD_MAX
		: period_word[16:0];
	wire logic [31:0] ctrl_word = merge_bytes({26'h0, ctrl}, DAT_I, SEL_I);

	// Status and read mux
	wire logic [31:0] status_word = (32'(running) << tagger_pkg::STAT_RUNNING_BIT)
		| (32'(state == tagger_pkg::ST_ARMED) << tagger_pkg::STAT_ARMED_BIT)
		| (32'(locked) << tagger_pkg::STAT_LOCKED_BIT)
		| (32'(REF_SEL_10M) << tagger_pkg::STAT_REF10_BIT)
		| (32'(fifo_empty) << tagger_pkg::STAT_EMPTY_BIT)
		| (32'(fifo_full) << tagger_pkg::STAT_FULL_BIT)
		| (32'(fill) << tagger_pkg::STAT_COUNT_LSB);
	wire logic [63:0] head_word = 64'(head);
	wire logic [31:0] rd_mux =
		(ADR_I == tagger_pkg::ADDR_CTRL) ? {26'h0, ctrl}
		: (ADR_I == tagger_pkg::ADDR_AUX_PERIOD) ? {15'h0, aux_period}
		: (ADR_I == tagger_pkg::ADDR_STATUS) ? status_word
		: (ADR_I == tagger_pkg::ADDR_TAG_LO) ? (head_ready ? head_word[31:0] : 32'h0)
		: (ADR_I == tagger_pkg::ADDR_TAG_HI) ? (head_ready ? head_word[63:32] : 32'h0)
		: (ADR_I == tagger_pkg::ADDR_SECONDS) ? {16'h0, seconds}
		: (ADR_I == tagger_pkg::ADDR_DROPS) ? drops
		: 32'h0;

	// Measurement state
	tagger_pkg::measure_state_type next_state;
	always_comb
	begin
		next_state = state;
		case (state)
			tagger_pkg::ST_IDLE:
				if (wr_ctrl && ctrl_word[tagger_pkg::CTRL_RUN_BIT])
					next_state = tagger_pkg::ST_RUNNING;
				else if (wr_ctrl && ctrl_word[tagger_pkg::CTRL_ARM_BIT])
					next_state = tagger_pkg::ST_ARMED;
			tagger_pkg::ST_ARMED:
				if (wr_ctrl && !ctrl_word[tagger_pkg::CTRL_ARM_BIT])
					next_state = tagger_pkg::ST_IDLE;
				else if (trig_rise)
					next_state = tagger_pkg::ST_RUNNING;
			tagger_pkg::ST_RUNNING:
				if (wr_ctrl && !ctrl_word[tagger_pkg::CTRL_RUN_BIT] && !ctrl_word[tagger_pkg::CTRL_ARM_BIT])
					next_state = tagger_pkg::ST_IDLE;
			default:
				next_state = tagger_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (!NRST)
			state <= tagger_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// Control registers
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			ctrl <= tagger_pkg::CTRL_RESET;
			aux_period <= tagger_pkg::AUX_PERIOD_RESET;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= ctrl_word[5:0];
			if (wr_period)
				aux_period <= period_clamped;
		end
	end

	// Input history
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
			prev_trig <= 1'b0;
			prev_pps <= 1'b0;
		end
		else
		begin
			prev_a <= EVENT_A;
			prev_b <= EVENT_B;
			prev_trig <= MEASURE_TRIGGER_IN;
			prev_pps <= SECOND_MARK_IN;
		end
	end

	// Dead time after every accepted event, shared by both inputs
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			dead <= 4'h0;
		else if (accept)
			dead <= tagger_pkg::DEAD_CYCLES;
		else if (dead != 4'h0)
			dead <= dead - 4'h1;
	end

	// Coarse scale in 10 ns quanta; a second marker restarts it on a new second
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			coarse <= 27'h0;
			seconds <= 16'h0;
		end
		else if (pps_rise)
		begin
			coarse <= 27'h0;
			seconds <= seconds + 16'h1;
		end
		else if (coarse_wrap)
		begin
			coarse <= 27'(coarse_sum - {1'b0, tagger_pkg::QUANTA_PER_SECOND});
			seconds <= seconds + 16'h1;
		end
		else
			coarse <= coarse_sum[26:0];
	end

	// Reference lock: the divider choice follows the detected reference frequency
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			REF_SEL_10M <= 1'b0;
			locked <= 1'b0;
		end
		else
		begin
			REF_SEL_10M <= REF_IS_10M;
			locked <= PLL_LOCKED;
		end
	end

	// Aux pulses; periods below one clock fire every cycle, a limit of the slow clock
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			aux_acc <= 18'h0;
			aux_len <= 4'h0;
			AUX_OUT <= 1'b0;
		end
		else
		begin
			if (wr_period)
				aux_acc <= 18'h0;
			else if (aux_fire)
				aux_acc <= aux_sum - {1'b0, aux_period};
			else
				aux_acc <= aux_sum;
			if (aux_fire && !wr_period)
				aux_len <= tagger_pkg::AUX_PULSE_CYCLES - 4'h1;
			else if (aux_len != 4'h0)
				aux_len <= aux_len - 4'h1;
			AUX_OUT <= (aux_fire && !wr_period) || aux_len != 4'h0;
		end
	end

	// Tag queue pointers; a tag that finds the queue full is counted, not stored
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			drops <= 32'h0;
			head_ok <= 1'b0;
		end
		else
		begin
			head_ok <= !fifo_empty;
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (accept && fifo_full)
				drops <= drops + 32'h1;
			else if (wr_drops)
				drops <= 32'h0;
		end
	end

	tag_mem u_mem
	(
		.clk(CLK),
		.wr_en(push),
		.wr_addr(wr_ptr[tagger_pkg::FIFO_AW-1:0]),
		.wr_data(new_tag),
		.rd_addr(rd_ptr[tagger_pkg::FIFO_AW-1:0]),
		.rd_data(head)
	);

	// Wishbone answer: one wait state, ack for one cycle
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0;
			read_valid <= 1'b0;
		end
		else
		begin
			ACK_O <= bus_req && !ACK_O;
			// A tag pops only if the word handed out was a real one
			if (bus_req && !ACK_O)
			begin
				DAT_O <= rd_mux;
				read_valid <= head_ready;
			end
		end
	end

endmodule : event_time_tagger_core

`default_nettype wire

// *** src/tagger_pkg.sv ***
// Constants, register map and carrier types of the event time-tagging core.
// Assumes a 10 MHz system clock and a classic Wishbone register bus with 32-bit data.
package tagger_pkg;

	// Clock and time scale
	localparam int CLK_PERIOD_NS = 100;
	localparam int QUANTUM_NS = 10;
	localparam logic [4:0] QUANTA_PER_CLK = 5'(CLK_PERIOD_NS / QUANTUM_NS);
	localparam int SECOND_NS = 1_000_000_000;
	localparam logic [26:0] QUANTA_PER_SECOND = 27'(SECOND_NS / QUANTUM_NS);

	// Dead time, a least time: round up, never below one cycle
	localparam int DEAD_TIME_NS = 40;
	localparam int DEAD_RAW = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] DEAD_CYCLES = 4'((DEAD_RAW < 1) ? 1 : DEAD_RAW);

	// Auxiliary pulse output
	localparam int AUX_PULSE_NS = 10;
	localparam int AUX_PULSE_RAW = (AUX_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] AUX_PULSE_CYCLES = 4'((AUX_PULSE_RAW < 1) ? 1 : AUX_PULSE_RAW);
	localparam int AUX_PERIOD_MIN_NS = 40;
	localparam int AUX_PERIOD_MAX_NS = 1_000_000;
	localparam logic [16:0] AUX_PERIOD_MIN = 17'(AUX_PERIOD_MIN_NS / QUANTUM_NS);
	localparam logic [16:0] AUX_PERIOD_MAX = 17'(AUX_PERIOD_MAX_NS / QUANTUM_NS);
	localparam logic [16:0] AUX_PERIOD_RESET = 17'h00064;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_AUX_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_TAG_LO = 8'h0c;
	localparam logic [7:0] ADDR_TAG_HI = 8'h10;
	localparam logic [7:0] ADDR_SECONDS = 8'h14;
	localparam logic [7:0] ADDR_DROPS = 8'h18;

	// Control fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_ARM_BIT = 1;
	localparam int CTRL_EDGE_A_LSB = 2;
	localparam int CTRL_EDGE_B_LSB = 4;
	localparam logic [5:0] CTRL_RESET = 6'h14;

	// Status fields
	localparam int STAT_RUNNING_BIT = 0;
	localparam int STAT_ARMED_BIT = 1;
	localparam int STAT_LOCKED_BIT = 2;
	localparam int STAT_REF10_BIT = 3;
	localparam int STAT_EMPTY_BIT = 4;
	localparam int STAT_FULL_BIT = 5;
	localparam int STAT_COUNT_LSB = 8;

	// Working edge codes
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;

	// Source markers
	localparam logic [1:0] MARK_A = 2'h1;
	localparam logic [1:0] MARK_B = 2'h2;

	// Tag queue
	localparam int FIFO_AW = 4;
	localparam logic [FIFO_AW:0] FIFO_DEPTH = 5'h10;

	typedef struct packed {
		logic [1:0] marker;
		logic [15:0] seconds;
		logic [26:0] coarse;
		logic [7:0] phase;
	} tag_type;

	localparam int TAG_WIDTH = $bits(tag_type);

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUNNING} measure_state_type;

endpackage : tagger_pkg

// *** src/tag_mem.sv ***
// Small tag memory for the tag queue: one write port, one read port.
// Read data come from a register, one cycle after the address.
`timescale 1ns/1ps
`default_nettype none

module tag_mem
(
	// Clock
	input wire logic clk,
	// Write side
	input wire logic wr_en,
	input wire logic [tagger_pkg::FIFO_AW-1:0] wr_addr,
	input wire tagger_pkg::tag_type wr_data,
	// Read side
	input wire logic [tagger_pkg::FIFO_AW-1:0] rd_addr,
	output tagger_pkg::tag_type rd_data
);

	tagger_pkg::tag_type mem [0:(1 << tagger_pkg::FIFO_AW)-1];

	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end

endmodule : tag_mem

`default_nettype wire

// *** testbench/event_time_tagger_core_assertions.sv ***
// Checker for the event time-tagging core, watching its top-level ports only.
// Assumes a single CLK domain with synchronous active-low NRST.
`timescale 1ns/1ps
`default_nettype none

module tagger_checker
(
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Bus
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_O,
	input wire logic ACK_O,
	// Reference and aux
	input wire logic PLL_LOCKED,
	input wire logic REF_IS_10M,
	input wire logic REF_SEL_10M,
	input wire logic AUX_OUT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);

	wire logic req = CYC_I && STB_I && !ACK_O;

	ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
	ack_latency_a: assert property (req |=> ACK_O) else $error("ack not one cycle after request");
	ack_cause_a: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I)) else $error("ack without request");
	read_hold_a: assert property (!(CYC_I && STB_I) && !ACK_O |=> $stable(DAT_O)) else $error("read data moved");
	unmapped_zero_a: assert property (req && !WE_I && (ADR_I > 8'h18 || ADR_I[1:0] != 2'h0) |=> DAT_O == 32'h0)
		else $error("unmapped read not zero");
	lock_report_a: assert property (req && !WE_I && ADR_I == 8'h08 |=> DAT_O[2] == $past(PLL_LOCKED, 2))
		else $error("lock bit wrong");
	ref_follow_a: assert property ($changed(REF_IS_10M) |=> REF_SEL_10M == $past(REF_IS_10M))
		else $error("reference select not following");
	aux_width_a: assert property (AUX_OUT |=> !AUX_OUT) else $error("aux pulse too long");

	cover property (req && WE_I);
	cover property (req && !WE_I && ADR_I == 8'h0c);
	cover property ($rose(AUX_OUT));
endmodule : tagger_checker

bind event_time_tagger_core tagger_checker i_tagger_checker (.CLK(CLK), .NRST(NRST), .CYC_I(CYC_I), .STB_I(STB_I),
	.WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .PLL_LOCKED(PLL_LOCKED), .REF_IS_10M(REF_IS_10M),
	.REF_SEL_10M(REF_SEL_10M), .AUX_OUT(AUX_OUT));
`default_nettype wire

// *** testbench/event_source.sv ***
// Model of the front end: comparators that turn hit requests into input edges.
// Assumes requests arrive as one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module event_source
(
	// Clock
	input wire logic clk,
	// Hit requests
	input wire logic hit_a,
	input wire logic hit_b,
	// Levels and interpolator codes
	output logic ev_a = 1'b0,
	output logic ev_b = 1'b0,
	output logic [7:0] phase_a,
	output logic [7:0] phase_b
);
	// Fixed codes so a tag shows which input's phase was kept
	assign phase_a = 8'h5a;
	assign phase_b = 8'ha5;
	// Each hit flips the level, so both edge kinds appear in turn
	always_ff @(posedge clk)
	begin
		if (hit_a) ev_a <= ~ev_a;
		if (hit_b) ev_b <= ~ev_b;
	end
endmodule : event_source
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the event time-tagging core.
// Assumes the core answers Wishbone requests one cycle after they are seen.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic CLK = 1'b0, NRST = 1'b0, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
	logic [7:0] ADR_I = 8'h00;
	logic [3:0] SEL_I = 4'h0;
	logic [31:0] DAT_I = 32'h0, DAT_O, q, cs;
	logic ACK_O, EVENT_A, EVENT_B, REF_SEL_10M, AUX_OUT, hit_a = 1'b0, hit_b = 1'b0;
	logic [7:0] PHASE_A, PHASE_B;
	logic GATE_B_IN = 1'b0, MEASURE_TRIGGER_IN = 1'b0, SECOND_MARK_IN = 1'b0, REF_IS_10M = 1'b1, PLL_LOCKED = 1'b1;
	int n_errors = 0, tests_run = 0, cyc_cnt = 0, n;

	event_time_tagger_core i_event_time_tagger_core (.CLK(CLK), .NRST(NRST), .CYC_I(CYC_I), .STB_I(STB_I),
		.WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .EVENT_A(EVENT_A),
		.EVENT_B(EVENT_B), .PHASE_A(PHASE_A), .PHASE_B(PHASE_B), .GATE_B_IN(GATE_B_IN),
		.MEASURE_TRIGGER_IN(MEASURE_TRIGGER_IN), .SECOND_MARK_IN(SECOND_MARK_IN), .REF_IS_10M(REF_IS_10M),
		.PLL_LOCKED(PLL_LOCKED), .REF_SEL_10M(REF_SEL_10M), .AUX_OUT(AUX_OUT));
	event_source i_event_source (.clk(CLK), .hit_a(hit_a), .hit_b(hit_b), .ev_a(EVENT_A), .ev_b(EVENT_B),
		.phase_a(PHASE_A), .phase_b(PHASE_B));

	initial
	begin
		forever #50 CLK = ~CLK;
	end

	task conclude;
		if (n_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// Whole run is a few hundred cycles; far above that means a hang
	always @(posedge CLK)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			n_errors++;
			conclude;
		end
	end

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= we;
		SEL_I <= 4'hf;
		ADR_I <= a;
		DAT_I <= d;
		do @(posedge CLK); while (ACK_O !== 1'b1);
		q = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
	endtask : wb

	task ev(input logic a, input logic b);
		@(posedge CLK);
		hit_a <= a;
		hit_b <= b;
		@(posedge CLK);
		hit_a <= 1'b0;
		hit_b <= 1'b0;
		repeat (3) @(posedge CLK);
	endtask : ev

	task fill(input int exp);
		wb(1'b0, 8'h08, 32'h0);
		chk("fill", exp, (q >> 8) & 32'h1f);
	endtask : fill

	task tag(input logic [1:0] mark, input logic [7:0] ph);
		tagger_pkg::tag_type t;
		wb(1'b0, 8'h10, 32'h0);
		t[52:32] = q[20:0];
		wb(1'b0, 8'h0c, 32'h0);
		t[31:0] = q;
		cs = {5'h0, t.coarse};
		chk("marker", {30'h0, mark}, {30'h0, t.marker});
		chk("phase", {24'h0, ph}, {24'h0, t.phase});
	endtask : tag

	initial
	begin
		repeat (10) @(posedge CLK);
		NRST <= 1'b1;
		wb(1'b0, 8'h00, 32'h0);
		chk("ctrl reset", 32'h14, q);
		wb(1'b0, 8'h04, 32'h0);
		chk("period reset", 32'h64, q);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, q);
		wb(1'b0, 8'h08, 32'h0);
		chk("status", 32'h1c, q);
		// Armed: edges wait for the trigger
		wb(1'b1, 8'h00, 32'h6);
		ev(1'b1, 1'b0);
		ev(1'b1, 1'b0);
		fill(0);
		@(posedge CLK) MEASURE_TRIGGER_IN <= 1'b1;
		@(posedge CLK) MEASURE_TRIGGER_IN <= 1'b0;
		wb(1'b0, 8'h08, 32'h0);
		chk("running", 32'h1, q & 32'h3);
		// Working edge codes on input A, one rise then one fall each
		for (int c = 1; c <= 3; c++)
		begin
			wb(1'b1, 8'h00, 32'h1 | (c << 2));
			ev(1'b1, 1'b0);
			ev(1'b1, 1'b0);
			n = (c == 3) ? 2 : 1;
			fill(n);
			repeat (n) tag(2'h1, 8'h5a);
		end
		// Gate blocks B while high
		wb(1'b1, 8'h00, 32'h11);
		GATE_B_IN <= 1'b1;
		ev(1'b0, 1'b1);
		ev(1'b0, 1'b1);
		GATE_B_IN <= 1'b0;
		ev(1'b0, 1'b1);
		fill(1);
		tag(2'h2, 8'ha5);
		// Merge and dead time: B one cycle after A is lost
		wb(1'b1, 8'h00, 32'h3d);
		ev(1'b1, 1'b1);
		@(posedge CLK) hit_a <= 1'b1;
		@(posedge CLK)
		begin
			hit_a <= 1'b0;
			hit_b <= 1'b1;
		end
		@(posedge CLK) hit_b <= 1'b0;
		ev(1'b0, 1'b0);
		fill(2);
		tag(2'h3, 8'h5a);
		n = cs;
		tag(2'h1, 8'h5a);
		chk("coarse step", 32'h32, cs - n);
		// Second marker counts seconds
		@(posedge CLK) SECOND_MARK_IN <= 1'b1;
		@(posedge CLK) SECOND_MARK_IN <= 1'b0;
		REF_IS_10M <= 1'b0;
		PLL_LOCKED <= 1'b0;
		wb(1'b0, 8'h14, 32'h0);
		chk("seconds", 32'h1, q);
		wb(1'b0, 8'h08, 32'h0);
		chk("lock ref", 32'h0, (q >> 2) & 32'h3);
		// Queue of 16 overflows by two
		repeat (18) ev(1'b1, 1'b0);
		wb(1'b0, 8'h08, 32'h0);
		chk("full", 32'h1, (q >> 5) & 32'h1);
		wb(1'b0, 8'h18, 32'h0);
		chk("drops", 32'h2, q);
		wb(1'b1, 8'h18, 32'h0);
		wb(1'b0, 8'h18, 32'h0);
		chk("drops clear", 32'h0, q);
		// Aux period 300 ns gives a rise every 3 cycles
		wb(1'b1, 8'h04, 32'h1e);
		for (int k = 0; k < 2; k++)
		begin
			n = 0;
			do @(posedge CLK); while (AUX_OUT !== 1'b1 && n++ < 50);
		end
		n = 0;
		do @(posedge CLK); while (AUX_OUT !== 1'b0 && n++ < 50);
		n = 2;
		do @(posedge CLK); while (AUX_OUT !== 1'b1 && n++ < 50);
		chk("aux spacing", 32'h3, n);
		conclude;
	end
endmodule : tb_top
`default_nettype wire
